// ===== core/icc_pkg.sv
package icc_pkg;
  localparam int          NUM_CHANNELS   = 8;
  localparam int          STAMP_W        = 16;
  localparam int          FIFO_DEPTH     = 4;
  localparam int          CTRL_W         = 16;
  // control register fields
  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 3;
  localparam int          IEC_LSB        = 5;
  localparam int          IEC_W          = 2;
  localparam int          TBS_BIT        = 7;
  localparam int          SIDL_BIT       = 13;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // capture mode encodings
  typedef enum logic [2:0] {
    ICC_MODE_OFF   = 3'b000,
    ICC_MODE_EVERY = 3'b001,
    ICC_MODE_FALL  = 3'b010,
    ICC_MODE_RISE  = 3'b011,
    ICC_MODE_RISE4 = 3'b100,
    ICC_MODE_RISE16= 3'b101,
    ICC_MODE_RSVD  = 3'b110,
    ICC_MODE_IRQ   = 3'b111
  } icc_mode_t;
  localparam logic [3:0]  PRE4_LAST      = 4'h3;
  localparam logic [3:0]  PRE16_LAST     = 4'hF;
  localparam logic [3:0]  PRE_ZERO       = 4'h0;
  localparam logic [2:0]  FILL_ZERO      = 3'h0;
  localparam logic [1:0]  IRQ_CNT_ZERO   = 2'h0;
  localparam logic [15:0] STAMP_ZERO     = 16'h0000;
endpackage

// ===== core/icc_channel.sv
`timescale 1ns/1ns
module icc_channel #(
  parameter int STAMP_W    = icc_pkg::STAMP_W,
  parameter int FIFO_DEPTH = icc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // configuration
  input  wire logic [2:0]         capture_mode_field,
  input  wire logic [1:0]         interrupt_event_count,
  input  wire logic               time_base_select,
  input  wire logic               stop_in_idle,
  input  wire logic               capture_irq_enable,
  // system state
  input  wire logic               cpu_idle,
  input  wire logic               cpu_sleep,
  input  wire logic               timer_a_on,
  input  wire logic               timer_b_on,
  input  wire logic [STAMP_W-1:0] timer_a_count,
  input  wire logic [STAMP_W-1:0] timer_b_count,
  // synchronised pin
  input  wire logic               pin_sync,
  // buffer read
  input  wire logic               buf_read,
  output logic [STAMP_W-1:0]      buf_data_ff,
  output logic                    buffer_not_empty_flag_ff,
  output logic                    capture_overflow_flag_ff,
  // interrupt and wake
  input  wire logic               irq_flag_clear,
  output logic                    capture_irq_flag_ff,
  output logic                    wake_request_ff
);
  logic [STAMP_W-1:0] fifo_ff [FIFO_DEPTH];
  logic [2:0]         fill_ff;
  logic [3:0]         pre_ff;
  logic [1:0]         irq_cnt_ff;
  logic               pin_prev_ff;
  logic               rise;
  logic               fall;
  logic               edge_ok;
  logic               tmr_on;
  logic               idle_ok;
  logic               do_read;
  logic               evt;
  logic               capt;
  logic               ovf_evt;
  logic               irq_evt;
  logic [3:0]         pre_last;
  logic               use_pre;
  logic               irq_only;
  logic [STAMP_W-1:0] stamp;
  logic [2:0]         fill_after;

  assign rise     = pin_sync & ~pin_prev_ff;
  assign fall     = ~pin_sync & pin_prev_ff;
  // zero selects the second timer
  assign tmr_on   = time_base_select ? timer_a_on : timer_b_on;
  assign stamp    = time_base_select ? timer_a_count
                                     : timer_b_count;
  assign idle_ok  = tmr_on & ~stop_in_idle;
  assign irq_only = (capture_mode_field == icc_pkg::ICC_MODE_IRQ);
  assign use_pre  = (capture_mode_field == icc_pkg::ICC_MODE_RISE4) |
                    (capture_mode_field == icc_pkg::ICC_MODE_RISE16);
  assign pre_last = (capture_mode_field == icc_pkg::ICC_MODE_RISE4)
                    ? icc_pkg::PRE4_LAST : icc_pkg::PRE16_LAST;

  always_comb
  begin
    unique case (capture_mode_field)
      icc_pkg::ICC_MODE_EVERY:  edge_ok = rise | fall;
      icc_pkg::ICC_MODE_FALL:   edge_ok = fall;
      icc_pkg::ICC_MODE_RISE,
      icc_pkg::ICC_MODE_RISE4,
      icc_pkg::ICC_MODE_RISE16,
      icc_pkg::ICC_MODE_IRQ:    edge_ok = rise;
      default:                  edge_ok = 1'b0;
    endcase
  end

  // in sleep only the interrupt-only mode responds, prescaler bypassed
  assign evt = edge_ok & ~(cpu_sleep & ~irq_only)
               & ~(cpu_idle & ~idle_ok & ~irq_only)
               & ~(use_pre & ~cpu_sleep & (pre_ff != pre_last));

  assign do_read = buf_read & buffer_not_empty_flag_ff;
  // overflow blocks captures until fully drained
  assign ovf_evt = evt & ~irq_only & (fill_ff == 3'(FIFO_DEPTH))
                   & (capture_mode_field != icc_pkg::ICC_MODE_EVERY);
  assign capt    = evt & ~irq_only & ~capture_overflow_flag_ff
                   & (fill_ff != 3'(FIFO_DEPTH));
  assign fill_after = fill_ff - {2'b00, do_read};

  always_comb
  begin
    if (cpu_sleep | irq_only | capture_mode_field == icc_pkg::ICC_MODE_EVERY)
      irq_evt = evt;
    else
      irq_evt = evt & (irq_cnt_ff == interrupt_event_count);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      pin_prev_ff <= 1'b0;
    else
      pin_prev_ff <= pin_sync;

  // prescaler counter
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      pre_ff <= icc_pkg::PRE_ZERO;
    else if (capture_mode_field == icc_pkg::ICC_MODE_OFF)
      pre_ff <= icc_pkg::PRE_ZERO;
    else if (use_pre & ~cpu_sleep & rise & ~(cpu_idle & ~idle_ok))
      pre_ff <= (pre_ff == pre_last) ? icc_pkg::PRE_ZERO : pre_ff + 4'h1;

  // fifo: read shifts entries toward the output
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      for (int i = 0; i < FIFO_DEPTH; i++)
        fifo_ff[i] <= icc_pkg::STAMP_ZERO;
      fill_ff <= icc_pkg::FILL_ZERO;
    end
    else
    begin
      if (do_read)
        for (int i = 0; i < FIFO_DEPTH - 1; i++)
          fifo_ff[i] <= fifo_ff[i+1];
      if (capt)
        fifo_ff[fill_after[1:0]] <= stamp;
      fill_ff <= fill_after + {2'b00, capt};
    end

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      buf_data_ff <= icc_pkg::STAMP_ZERO;
    else if (do_read)
      buf_data_ff <= fifo_ff[0];

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      buffer_not_empty_flag_ff <= 1'b0;
    else
      buffer_not_empty_flag_ff <= (fill_after != icc_pkg::FILL_ZERO)
                                  | capt;

  // cleared once the buffer has drained
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      capture_overflow_flag_ff <= 1'b0;
    else if (ovf_evt)
      capture_overflow_flag_ff <= 1'b1;
    else if (fill_after == icc_pkg::FILL_ZERO)
      capture_overflow_flag_ff <= 1'b0;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      irq_cnt_ff <= icc_pkg::IRQ_CNT_ZERO;
    else if (capture_mode_field == icc_pkg::ICC_MODE_OFF | irq_evt)
      irq_cnt_ff <= icc_pkg::IRQ_CNT_ZERO;
    else if (evt)
      irq_cnt_ff <= irq_cnt_ff + 2'h1;

  // set wins over clear
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      capture_irq_flag_ff <= 1'b0;
    else if (irq_evt)
      capture_irq_flag_ff <= 1'b1;
    else if (irq_flag_clear)
      capture_irq_flag_ff <= 1'b0;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      wake_request_ff <= 1'b0;
    else
      wake_request_ff <= irq_evt & capture_irq_enable
                         & (cpu_sleep | cpu_idle);
endmodule // icc_channel

// ===== core/icc_top.sv
// Operation
// - up to eight independent channels, each with own settings and flags
// - mode field bits 2:0 picks falling, rising, 4th, 16th or both edges
// - mode value also sets the prescale ratio of edges counted
// - prescaler counter cleared when the channel mode is off
// - any reset clears the prescaler counter
// - four-entry, 16-bit capture buffer per channel
// - not-empty flag set on capture, held until buffer drained
// - a read returns oldest entry and shifts the rest forward
// - capture with four unread entries sets the overflow flag
// - the overflowing capture is discarded
// - after overflow, captures ignored until all four entries read
// - control bit 7 selects which timer count is captured
// - after reset the second timer is the time base
// - mode 001 flags an interrupt on every rising and falling edge
// - every-edge mode ignores the interrupt event count
// - every-edge mode never raises overflow
// - enabled interrupt event in idle or sleep requests wake or interrupt
// - mode 111 with enable wakes the device even if timer off
// - in sleep the event count is ignored, pin acts as interrupt
// - divide-by-4 and divide-by-16 not applied during sleep
// - control bits 6:5 choose captures per interrupt
// - idle keeps full function only with timer on and stop-in-idle zero
`timescale 1ns/1ns
module icc_top #(
  parameter int NUM_CHANNELS = icc_pkg::NUM_CHANNELS,
  parameter int STAMP_W      = icc_pkg::STAMP_W
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  // per-channel control registers, packed by channel
  input  wire logic [16*NUM_CHANNELS-1:0] channel_control_reg,
  // system state
  input  wire logic                      cpu_idle,
  input  wire logic                      cpu_sleep,
  // timers
  input  wire logic                      timer_a_on,
  input  wire logic                      timer_b_on,
  input  wire logic [STAMP_W-1:0]        timer_a_count,
  input  wire logic [STAMP_W-1:0]        timer_b_count,
  // capture pins
  input  wire logic [NUM_CHANNELS-1:0]   capture_pin,
  // buffer reads
  input  wire logic [NUM_CHANNELS-1:0]   buf_read,
  output logic [STAMP_W*NUM_CHANNELS-1:0] buf_data_ff,
  // status
  output logic [NUM_CHANNELS-1:0]        buffer_not_empty_flag_ff,
  output logic [NUM_CHANNELS-1:0]        capture_overflow_flag_ff,
  // interrupts
  input  wire logic [NUM_CHANNELS-1:0]   capture_irq_enable,
  input  wire logic [NUM_CHANNELS-1:0]   irq_flag_clear,
  output logic [NUM_CHANNELS-1:0]        capture_irq_flag_ff,
  output logic [NUM_CHANNELS-1:0]        wake_request_ff
);
  // two-flop pin synchroniser; first stage read only by the second
  logic [NUM_CHANNELS-1:0] pin_meta_ff;
  logic [NUM_CHANNELS-1:0] pin_sync_ff;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= capture_pin;
      pin_sync_ff <= pin_meta_ff;
    end

  for (genvar c = 0; c < NUM_CHANNELS; c++)
  begin : g_chan
    logic [15:0] ctl;
    assign ctl = channel_control_reg[16*c +: 16];
    // bit 7 reset value zero selects the second timer
    icc_channel #(
      .STAMP_W (STAMP_W)
    ) u_chan (
      .ref_clk                  (ref_clk),
      .rst_b                    (rst_b),
      .capture_mode_field       (ctl[icc_pkg::MODE_LSB +: icc_pkg::MODE_W]),
      .interrupt_event_count    (ctl[icc_pkg::IEC_LSB +: icc_pkg::IEC_W]),
      .time_base_select         (ctl[icc_pkg::TBS_BIT]),
      .stop_in_idle             (ctl[icc_pkg::SIDL_BIT]),
      .capture_irq_enable       (capture_irq_enable[c]),
      .cpu_idle                 (cpu_idle),
      .cpu_sleep                (cpu_sleep),
      .timer_a_on               (timer_a_on),
      .timer_b_on               (timer_b_on),
      .timer_a_count            (timer_a_count),
      .timer_b_count            (timer_b_count),
      .pin_sync                 (pin_sync_ff[c]),
      .buf_read                 (buf_read[c]),
      .buf_data_ff              (buf_data_ff[STAMP_W*c +: STAMP_W]),
      .buffer_not_empty_flag_ff (buffer_not_empty_flag_ff[c]),
      .capture_overflow_flag_ff (capture_overflow_flag_ff[c]),
      .irq_flag_clear           (irq_flag_clear[c]),
      .capture_irq_flag_ff      (capture_irq_flag_ff[c]),
      .wake_request_ff          (wake_request_ff[c])
    );
  end
endmodule // icc_top

// ===== test/icc_top_chk.sv
`timescale 1ns/1ns
module icc_top_chk #(
  parameter int NUM_CHANNELS = 8,
  parameter int STAMP_W      = 16
) (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst_b,
  // inputs watched
  input wire logic [16*NUM_CHANNELS-1:0] channel_control_reg,
  input wire logic [NUM_CHANNELS-1:0]    buf_read,
  input wire logic [NUM_CHANNELS-1:0]    irq_flag_clear,
  // outputs watched
  input wire logic [STAMP_W*NUM_CHANNELS-1:0] buf_data_ff,
  input wire logic [NUM_CHANNELS-1:0]    buffer_not_empty_flag_ff,
  input wire logic [NUM_CHANNELS-1:0]    capture_overflow_flag_ff,
  input wire logic [NUM_CHANNELS-1:0]    capture_irq_flag_ff,
  input wire logic [NUM_CHANNELS-1:0]    wake_request_ff
);
  logic [2:0] mode0;
  logic       ne0;
  logic       ov0;
  assign mode0 = channel_control_reg[2:0];
  assign ne0   = buffer_not_empty_flag_ff[0];
  assign ov0   = capture_overflow_flag_ff[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_one_pulse;
    wake_request_ff[0] ##1 !wake_request_ff[0];
  endsequence
  a_data_on_read: assert property (
    $changed(buf_data_ff[15:0]) |-> $past(buf_read[0]))
    else $error("buffer data moved without a read");
  a_ne_holds: assert property (ne0 && !buf_read[0] |=> ne0)
    else $error("not-empty dropped without a read");
  a_ovf_when_full: assert property ($rose(ov0) |-> $past(ne0))
    else $error("overflow raised on empty buffer");
  a_ovf_clear_empty: assert property ($fell(ov0) |-> !ne0)
    else $error("overflow cleared before buffer drained");
  a_every_no_ovf: assert property (
    mode0 == icc_pkg::ICC_MODE_EVERY && !ov0 |=> !ov0)
    else $error("overflow in every-edge mode");
  a_every_irq: assert property (
    $rose(ne0) && mode0 == icc_pkg::ICC_MODE_EVERY |-> capture_irq_flag_ff[0])
    else $error("every-edge capture without irq flag");
  a_irq_sticky: assert property (
    capture_irq_flag_ff[0] && !irq_flag_clear[0] |=> capture_irq_flag_ff[0])
    else $error("irq flag lost without clear");
  a_wake_pulse: assert property (wake_request_ff[0] |-> s_one_pulse)
    else $error("wake longer than one cycle");
  a_wake_flag: assert property (
    wake_request_ff[0] |-> capture_irq_flag_ff[0])
    else $error("wake without irq flag");
endmodule // icc_top_chk

// ===== test/icc_far_end.sv
`timescale 1ns/1ns
module icc_far_end (
  // pins and timers
  output logic [1:0]  capture_pin,
  output logic        timer_a_on,
  output logic        timer_b_on,
  output logic [15:0] timer_a_count,
  output logic [15:0] timer_b_count
);
  initial
  begin
    capture_pin   = 2'h0;
    timer_a_on    = 1'b1;
    timer_b_on    = 1'b1;
    timer_a_count = 16'h0000;
    timer_b_count = 16'h0000;
  end
  // counts held still around each edge so the stamp is known
  task automatic drive(input int c, input logic v, input logic [15:0] s);
    timer_a_count  = ~s;
    timer_b_count  = s;
    capture_pin[c] = v;
  endtask
  task automatic power(input logic a, input logic b);
    timer_a_on = a;
    timer_b_on = b;
  endtask
endmodule // icc_far_end

// ===== test/tb_icc_top.sv
`timescale 1ns/1ns
module tb_icc_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] ctrl;
  logic        cpu_idle;
  logic        cpu_sleep;
  logic        ta_on;
  logic        tb_on;
  logic [15:0] ta;
  logic [15:0] tbc;
  logic [1:0]  pin;
  logic [1:0]  rd_s;
  logic [1:0]  ien;
  logic [1:0]  clr;
  logic [31:0] bdata;
  logic [1:0]  ne;
  logic [1:0]  ovf;
  logic [1:0]  irq;
  logic [1:0]  wake;
  int          err_count;
  int          compares;
  int          cycles;
  int          wakes;
  always #2 ref_clk = ~ref_clk;
  icc_far_end icc_far_end_i (.capture_pin(pin), .timer_a_on(ta_on),
    .timer_b_on(tb_on), .timer_a_count(ta), .timer_b_count(tbc));
  icc_top #(.NUM_CHANNELS(2)) icc_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .channel_control_reg(ctrl), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .timer_a_on(ta_on), .timer_b_on(tb_on), .timer_a_count(ta),
    .timer_b_count(tbc), .capture_pin(pin), .buf_read(rd_s),
    .buf_data_ff(bdata), .buffer_not_empty_flag_ff(ne),
    .capture_overflow_flag_ff(ovf), .capture_irq_enable(ien),
    .irq_flag_clear(clr), .capture_irq_flag_ff(irq),
    .wake_request_ff(wake));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (wake[0] === 1'b1)
      wakes++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pin_to(input int c, input logic v, input logic [15:0] s);
    icc_far_end_i.drive(c, v, s);
    cyc(5);
  endtask
  task automatic pulse(input int c, input logic [15:0] s);
    pin_to(c, 1'b1, s);
    pin_to(c, 1'b0, s + 16'h0001);
  endtask
  task automatic rd(input int c);
    chk("ne_rd", 16'(ne[c]), 16'h0001);
    rd_s[c] = 1'b1;
    cyc(1);
    rd_s[c] = 1'b0;
    cyc(2);
  endtask
  task automatic clr0;
    clr[0] = 1'b1;
    cyc(1);
    clr[0] = 1'b0;
    cyc(1);
  endtask
  task automatic t_fifo;
    chk("ne", 16'(ne[0]), 16'h0000);
    ctrl[15:0] = 16'h0003;
    for (int i = 0; i < 5; i++)
      pulse(0, 16'h2000 + 16'(i));
    chk("ovf", 16'(ovf[0]), 16'h0001);
    rd(0);
    pulse(0, 16'h2100);
    for (int i = 1; i < 4; i++)
    begin
      rd(0);
      chk("data", bdata[15:0], 16'h2000 + 16'(i));
      chk("ne", 16'(ne[0]), 16'(i < 3));
    end
    chk("ovf", 16'(ovf[0]), 16'h0000);
    ctrl[31:16] = 16'h0083;
    pulse(1, 16'h0055);
    rd(1);
    chk("data1", bdata[31:16], 16'hFFAA);
    chk("ne", 16'(ne[0]), 16'h0000);
    $display("test fifo done");
  endtask
  task automatic t_every;
    clr0();
    ctrl[15:0] = 16'h0061;
    pin_to(0, 1'b1, 16'h3000);
    chk("irq", 16'(irq[0]), 16'h0001);
    clr0();
    chk("irq", 16'(irq[0]), 16'h0000);
    pin_to(0, 1'b0, 16'h3001);
    chk("irq", 16'(irq[0]), 16'h0001);
    for (int i = 2; i < 6; i++)
      pin_to(0, ~i[0], 16'h3000 + 16'(i));
    chk("ovf", 16'(ovf[0]), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      rd(0);
      chk("data", bdata[15:0], 16'h3000 + 16'(i));
    end
    $display("test every done");
  endtask
  task automatic t_presc;
    ctrl[15:0] = 16'h0004;
    pulse(0, 16'h4000);
    pulse(0, 16'h4000);
    ctrl[15:0] = 16'h0000;
    cyc(2);
    ctrl[15:0] = 16'h0004;
    for (int i = 0; i < 3; i++)
      pulse(0, 16'h4000);
    chk("ne", 16'(ne[0]), 16'h0000);
    pulse(0, 16'h4444);
    rd(0);
    chk("data", bdata[15:0], 16'h4444);
    ctrl[15:0] = 16'h0002;
    pulse(0, 16'h5000);
    rd(0);
    chk("data", bdata[15:0], 16'h5001);
    ctrl[15:0] = 16'h0005;
    for (int i = 0; i < 15; i++)
      pulse(0, 16'h5500);
    chk("ne", 16'(ne[0]), 16'h0000);
    pulse(0, 16'h5516);
    rd(0);
    chk("data", bdata[15:0], 16'h5516);
    $display("test prescale done");
  endtask
  task automatic t_sleep;
    clr0();
    ctrl[15:0] = 16'h0067;
    ien[0] = 1'b1;
    icc_far_end_i.power(1'b0, 1'b0);
    cpu_sleep = 1'b1;
    wakes = 0;
    pulse(0, 16'h6000);
    chk("wakes", 16'(wakes), 16'h0001);
    chk("irq", 16'(irq[0]), 16'h0001);
    ctrl[15:0] = 16'h0004;
    for (int i = 0; i < 4; i++)
      pulse(0, 16'h6100);
    chk("ne", 16'(ne[0]), 16'h0000);
    cpu_sleep = 1'b0;
    icc_far_end_i.power(1'b1, 1'b0);
    cpu_idle = 1'b1;
    ctrl[15:0] = 16'h0003;
    pulse(0, 16'h6800);
    chk("ne", 16'(ne[0]), 16'h0000);
    icc_far_end_i.power(1'b1, 1'b1);
    ctrl[15:0] = 16'h2003;
    pulse(0, 16'h7000);
    chk("ne", 16'(ne[0]), 16'h0000);
    ctrl[15:0] = 16'h0003;
    pulse(0, 16'h7100);
    chk("ne", 16'(ne[0]), 16'h0001);
    cpu_idle = 1'b0;
    $display("test sleep done");
  endtask
  initial
  begin
    ctrl = '0;
    cpu_idle = 1'b0;
    cpu_sleep = 1'b0;
    rd_s = 2'h0;
    ien = 2'h0;
    clr = 2'h0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    wakes = 0;
    cyc(6);
    rst_b = 1'b1;
    cyc(2);
    t_fifo();
    t_every();
    t_presc();
    t_sleep();
    end_of_test();
  end
endmodule // tb_icc_top
bind icc_top icc_top_chk #(.NUM_CHANNELS(NUM_CHANNELS), .STAMP_W(STAMP_W))
  icc_top_chk_i (.ref_clk(ref_clk), .rst_b(rst_b),
  .channel_control_reg(channel_control_reg), .buf_read(buf_read),
  .irq_flag_clear(irq_flag_clear), .buf_data_ff(buf_data_ff),
  .buffer_not_empty_flag_ff(buffer_not_empty_flag_ff),
  .capture_overflow_flag_ff(capture_overflow_flag_ff),
  .capture_irq_flag_ff(capture_irq_flag_ff),
  .wake_request_ff(wake_request_ff));
